// ---- verilog/pll_function_config_decode.sv ----
// Notes on behaviour
// RQ1: selector codes 0, 1 and 2 give high impedance, driven high and driven low on the test/lock pin.
// RQ2: codes 3, 4 and 5 drive the combined, main-only and aux-only digital lock push-pull.
// RQ3: codes 6 to 8 give open-drain analog lock (both, main, aux) and 9 to 11 the same push-pull.
// RQ4: codes 12 to 15 drive the aux reference, aux feedback, main reference, main feedback dividers halved.
// RQ5: differential reference enable 0 clocks both reference counters single-ended, 1 differentially.
// RQ6: doubler enable 0 bypasses the doubler so the aux reference counter sees the plain reference.
// RQ7: auto power-up 0 is off, 1 powers the main synth and 2 both on a main divider write, 3 reserved.
// RQ8: an auto power-up overrides the charge-pump high-impedance bit.
// RQ9: modulator order code 0 gives fourth, 2 second and 3 third order.
// RQ10: modulator order code 1 turns the modulator off, meant for test only.
// RQ11: width select 0 gives 12-bit fractions up to 4095, 1 gives 22-bit up to 4194303.
// RQ12: in 22-bit mode the numerator is the 10-bit extension above the 12-bit low field, else extension ignored.
// RQ13: software zeroes the extension bits for 22-bit numerators below 4096.
// RQ14: aux pump polarity 1 is positive, 0 negative.
// RQ15: main pump polarity 1 is positive (normal), 0 negative.
// RQ16: each pump high-impedance bit 0 keeps the pump active, 1 floats it.
// RQ17: a register updates only from a whole 24-bit word carrying its address, taken on load rise.
`timescale 1ns/1ps
`default_nettype none
module pll_function_config_decode
  import pll_cfg_pkg::*;
(
  input  wire logic                 CLK_I,
  input  wire logic                 NRST_I,
  input  wire logic                 SER_DATA_I,
  input  wire logic                 SER_CLK_I,
  input  wire logic                 SER_LOAD_I,
  input  wire lock_src_type         LOCK_SRC_I,
  input  wire logic [LOW_BITS-1:0]  NUMERATOR_LOWER_I,
  output logic                      TEST_LOCK_O,
  output logic                      TEST_LOCK_OE_O,
  output logic                      REF_DIFF_SEL_O,
  output logic                      REF_DOUBLER_EN_O,
  output logic                      MAIN_PUMP_POL_O,
  output logic                      AUX_PUMP_POL_O,
  output logic                      MAIN_PUMP_HIGHZ_O,
  output logic                      AUX_PUMP_HIGHZ_O,
  output logic                      MAIN_POWER_UP_O,
  output logic                      AUX_POWER_UP_O,
  output logic                      MOD_ENABLE_O,
  output logic [2:0]                MOD_ORDER_O,
  output logic                      WIDE_MODE_O,
  output logic [FRAC_BITS-1:0]      NUMERATOR_O,
  output logic [UP_BITS-1:0]        DENOM_UPPER_O
);
  initial begin
    if (FRAC_BITS != LOW_BITS + UP_BITS) $error("fraction width mismatch");
  end

  ////////////////////////////////////////////////////////////////////////
  // serial word intake
  logic [WORD_BITS-1:0] word;
  logic                 word_valid;

  serial_word_capture #(
    .BITS         (WORD_BITS)
  ) u_capture (
    .clk_i        (CLK_I),
    .nrst_i       (NRST_I),
    .ser_data_i   (SER_DATA_I),
    .ser_clk_i    (SER_CLK_I),
    .ser_load_i   (SER_LOAD_I),
    .word_o       (word),
    .word_valid_o (word_valid)
  );

  logic [3:0] word_addr;
  logic       func_wr;
  logic       ext_wr;
  logic       main_div_wr;

  assign word_addr   = word[ADDR_MSB:ADDR_LSB];
  assign func_wr     = word_valid && (word_addr == ADDR_FUNC_CTRL); // [RQ17]
  assign ext_wr      = word_valid && (word_addr == ADDR_FRAC_EXT); // [RQ17]
  assign main_div_wr = word_valid && (word[MAIN_DIV_FLAG_BIT] == MAIN_DIV_FLAG);

  ////////////////////////////////////////////////////////////////////////
  // lock and divider inputs: two-flop crossing plus history for edges
  lock_src_type lock_meta_reg;
  lock_src_type lock_sync_reg;
  logic [3:0]   div_prev_reg;
  logic [3:0]   div_half_reg;
  logic [3:0]   div_prev_next;
  logic [3:0]   div_half_next;
  logic [3:0]   div_now;

  assign div_now = {lock_sync_reg.aux_ref_div, lock_sync_reg.aux_fb_div,
                    lock_sync_reg.main_ref_div, lock_sync_reg.main_fb_div};

  // halve each divider output on its rising edge
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_half
      always_comb begin
        div_prev_next[gi] = div_now[gi];
        div_half_next[gi] = div_half_reg[gi] ^ (div_now[gi] & ~div_prev_reg[gi]); // [RQ4]
      end
    end
  endgenerate

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      lock_meta_reg <= 8'h00;
      lock_sync_reg <= 8'h00;
      div_prev_reg  <= 4'h0;
      div_half_reg  <= 4'h0;
    end else begin
      lock_meta_reg <= LOCK_SRC_I;
      lock_sync_reg <= lock_meta_reg;
      div_prev_reg  <= div_prev_next;
      div_half_reg  <= div_half_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  func_ctrl_type        func_reg;
  func_ctrl_type        func_next;
  logic [UP_BITS-1:0]   fn_up_reg;
  logic [UP_BITS-1:0]   fn_up_next;
  logic [UP_BITS-1:0]   fd_up_reg;
  logic [UP_BITS-1:0]   fd_up_next;
  logic                 main_ovr_reg;
  logic                 main_ovr_next;
  logic                 aux_ovr_reg;
  logic                 aux_ovr_next;
  logic                 main_pwr_next;
  logic                 aux_pwr_next;

  always_comb begin
    func_next     = func_reg;
    fn_up_next    = fn_up_reg;
    fd_up_next    = fd_up_reg;
    main_ovr_next = main_ovr_reg;
    aux_ovr_next  = aux_ovr_reg;
    main_pwr_next = 1'b0;
    aux_pwr_next  = 1'b0;
    if (func_wr) begin
      func_next     = func_ctrl_type'(word[FUNC_MSB:FUNC_LSB]); // [RQ17]
      main_ovr_next = 1'b0;
      aux_ovr_next  = 1'b0;
    end
    if (ext_wr) begin
      fn_up_next = word[FN_UP_MSB:FN_UP_LSB]; // [RQ17]
      fd_up_next = word[FD_UP_MSB:FD_UP_LSB];
    end
    if (main_div_wr) begin
      case (func_reg.auto_power_up)
        AUTO_MAIN: begin
          main_pwr_next = 1'b1; // [RQ7]
          main_ovr_next = 1'b1;
        end
        AUTO_BOTH: begin
          main_pwr_next = 1'b1; // [RQ7]
          aux_pwr_next  = 1'b1;
          main_ovr_next = 1'b1;
          aux_ovr_next  = 1'b1;
        end
        default: begin
          main_pwr_next = 1'b0; // [RQ7]
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      func_reg     <= FUNC_CTRL_RESET;
      fn_up_reg    <= UP_ZERO;
      fd_up_reg    <= UP_ZERO;
      main_ovr_reg <= 1'h0;
      aux_ovr_reg  <= 1'h0;
    end else begin
      func_reg     <= func_next;
      fn_up_reg    <= fn_up_next;
      fd_up_reg    <= fd_up_next;
      main_ovr_reg <= main_ovr_next;
      aux_ovr_reg  <= aux_ovr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test/lock pin selection: returns {drive_enable, level}
  function automatic logic [1:0] pin_select(input sel_type sel, input lock_src_type s,
                                            input logic [3:0] half);
    logic dig_both;
    logic ana_both;
    dig_both = s.dig_main & s.dig_aux;
    ana_both = s.ana_main & s.ana_aux;
    case (sel)
      SEL_HIGHZ:    pin_select = 2'h0;
      SEL_HIGH:     pin_select = 2'h3;
      SEL_LOW:      pin_select = 2'h2;
      SEL_DIG_BOTH: pin_select = {1'b1, dig_both};
      SEL_DIG_MAIN: pin_select = {1'b1, s.dig_main};
      SEL_DIG_AUX:  pin_select = {1'b1, s.dig_aux};
      SEL_OD_BOTH:  pin_select = {~ana_both, 1'b0};
      SEL_OD_MAIN:  pin_select = {~s.ana_main, 1'b0};
      SEL_OD_AUX:   pin_select = {~s.ana_aux, 1'b0};
      SEL_ANA_BOTH: pin_select = {1'b1, ana_both};
      SEL_ANA_MAIN: pin_select = {1'b1, s.ana_main};
      SEL_ANA_AUX:  pin_select = {1'b1, s.ana_aux};
      SEL_AUX_REF:  pin_select = {1'b1, half[3]};
      SEL_AUX_FB:   pin_select = {1'b1, half[2]};
      SEL_MAIN_REF: pin_select = {1'b1, half[1]};
      SEL_MAIN_FB:  pin_select = {1'b1, half[0]};
      default:      pin_select = 2'h0;
    endcase
  endfunction : pin_select

  ////////////////////////////////////////////////////////////////////////
  // output stage
  logic [1:0]           pin_next;
  logic [2:0]           order_next;
  logic [FRAC_BITS-1:0] num_next;

  always_comb begin
    pin_next = pin_select(func_reg.output_selector, lock_sync_reg, div_half_reg); // [RQ1] [RQ2] [RQ3] [RQ4]
    case (func_reg.modulator_order)
      MOD_FOURTH: order_next = ORDER_FOURTH; // [RQ9]
      MOD_SECOND: order_next = ORDER_SECOND; // [RQ9]
      MOD_THIRD:  order_next = ORDER_THIRD; // [RQ9]
      MOD_OFF:    order_next = ORDER_NONE; // [RQ10]
      default:    order_next = ORDER_NONE;
    endcase
    // narrow mode ignores the extension bits
    if (func_reg.denominator_width_select) begin
      num_next = {fn_up_reg, NUMERATOR_LOWER_I}; // [RQ11] [RQ12]
    end else begin
      num_next = {UP_ZERO, NUMERATOR_LOWER_I}; // [RQ11] [RQ12]
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      TEST_LOCK_O       <= 1'h0;
      TEST_LOCK_OE_O    <= 1'h0;
      REF_DIFF_SEL_O    <= 1'h0;
      REF_DOUBLER_EN_O  <= 1'h0;
      MAIN_PUMP_POL_O   <= 1'h0;
      AUX_PUMP_POL_O    <= 1'h0;
      MAIN_PUMP_HIGHZ_O <= 1'h0;
      AUX_PUMP_HIGHZ_O  <= 1'h0;
      MAIN_POWER_UP_O   <= 1'h0;
      AUX_POWER_UP_O    <= 1'h0;
      MOD_ENABLE_O      <= 1'h0;
      MOD_ORDER_O       <= ORDER_NONE;
      WIDE_MODE_O       <= 1'h0;
      NUMERATOR_O       <= '0;
      DENOM_UPPER_O     <= UP_ZERO;
    end else begin
      TEST_LOCK_O       <= pin_next[0];
      TEST_LOCK_OE_O    <= pin_next[1];
      REF_DIFF_SEL_O    <= func_reg.diff_reference_enable; // [RQ5]
      REF_DOUBLER_EN_O  <= func_reg.reference_doubler_enable; // [RQ6]
      MAIN_PUMP_POL_O   <= func_reg.main_pump_polarity; // [RQ15]
      AUX_PUMP_POL_O    <= func_reg.aux_pump_polarity; // [RQ14]
      MAIN_PUMP_HIGHZ_O <= func_reg.main_pump_highz & ~main_ovr_reg; // [RQ16] [RQ8]
      AUX_PUMP_HIGHZ_O  <= func_reg.aux_pump_highz & ~aux_ovr_reg; // [RQ16] [RQ8]
      MAIN_POWER_UP_O   <= main_pwr_next;
      AUX_POWER_UP_O    <= aux_pwr_next;
      MOD_ENABLE_O      <= (func_reg.modulator_order != MOD_OFF); // [RQ10]
      MOD_ORDER_O       <= order_next;
      WIDE_MODE_O       <= func_reg.denominator_width_select; // [RQ11]
      NUMERATOR_O       <= num_next;
      DENOM_UPPER_O     <= fd_up_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic dig_both_h;
  assign dig_both_h = lock_sync_reg.dig_main & lock_sync_reg.dig_aux;

  AST_SEL_HIGHZ: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ1]
    func_reg.output_selector == SEL_HIGHZ |=> !TEST_LOCK_OE_O)
    else $error("selector 0 did not float the pin");
  AST_SEL_LEVELS: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ1]
    func_reg.output_selector inside {SEL_HIGH, SEL_LOW}
    |=> TEST_LOCK_OE_O && (TEST_LOCK_O == $past(func_reg.output_selector == SEL_HIGH)))
    else $error("constant level selector wrong");
  AST_DIG_BOTH: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ2]
    func_reg.output_selector == SEL_DIG_BOTH |=> TEST_LOCK_OE_O && TEST_LOCK_O == $past(dig_both_h))
    else $error("combined digital lock wrong");
  AST_OPEN_DRAIN: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ3]
    func_reg.output_selector inside {SEL_OD_BOTH, SEL_OD_MAIN, SEL_OD_AUX} |=> !TEST_LOCK_O)
    else $error("open-drain selector drove high");
  AST_AUTO_PULSE: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ7]
    main_div_wr && func_reg.auto_power_up == AUTO_BOTH |-> ##1 MAIN_POWER_UP_O && AUX_POWER_UP_O ##1
    !MAIN_POWER_UP_O)
    else $error("auto power-up pulse wrong");
  AST_AUTO_OVERRIDE: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ8]
    main_ovr_reg |=> !MAIN_PUMP_HIGHZ_O)
    else $error("pump floated despite auto power-up");
  AST_MOD_OFF: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ10]
    func_reg.modulator_order == MOD_OFF |=> !MOD_ENABLE_O && MOD_ORDER_O == ORDER_NONE)
    else $error("modulator not disabled");
  AST_NARROW_NUM: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ12]
    !func_reg.denominator_width_select |=> NUMERATOR_O[FRAC_BITS-1:LOW_BITS] == UP_ZERO)
    else $error("extension leaked in 12-bit mode");
  AST_ADDR_ONLY: assert property (@(posedge CLK_I) disable iff (!NRST_I) // [RQ17]
    !func_wr |=> $stable(func_reg))
    else $error("function register changed without its word");
endmodule : pll_function_config_decode
`default_nettype wire

// ---- shared/pll_cfg_pkg.sv ----
package pll_cfg_pkg;
  localparam int WORD_BITS = 24;
  localparam int ADDR_LSB  = 0;
  localparam int ADDR_MSB  = 3;
  localparam int FUNC_LSB  = 4;
  localparam int FUNC_MSB  = 18;
  localparam int FN_UP_LSB = 4;
  localparam int FN_UP_MSB = 13;
  localparam int FD_UP_LSB = 14;
  localparam int FD_UP_MSB = 23;
  localparam int LOW_BITS  = 12;
  localparam int UP_BITS   = 10;
  localparam int FRAC_BITS = 22;
  localparam int MAIN_DIV_FLAG_BIT = 0;

  localparam logic [3:0] ADDR_FUNC_CTRL = 4'hB;
  localparam logic [3:0] ADDR_FRAC_EXT  = 4'hD;
  localparam logic       MAIN_DIV_FLAG  = 1'h0;
  localparam logic [9:0] UP_ZERO        = 10'h000;

  typedef enum logic [3:0] {
    SEL_HIGHZ    = 4'h0,
    SEL_HIGH     = 4'h1,
    SEL_LOW      = 4'h2,
    SEL_DIG_BOTH = 4'h3,
    SEL_DIG_MAIN = 4'h4,
    SEL_DIG_AUX  = 4'h5,
    SEL_OD_BOTH  = 4'h6,
    SEL_OD_MAIN  = 4'h7,
    SEL_OD_AUX   = 4'h8,
    SEL_ANA_BOTH = 4'h9,
    SEL_ANA_MAIN = 4'hA,
    SEL_ANA_AUX  = 4'hB,
    SEL_AUX_REF  = 4'hC,
    SEL_AUX_FB   = 4'hD,
    SEL_MAIN_REF = 4'hE,
    SEL_MAIN_FB  = 4'hF
  } sel_type;

  typedef enum logic [1:0] {
    AUTO_OFF  = 2'h0,
    AUTO_MAIN = 2'h1,
    AUTO_BOTH = 2'h2,
    AUTO_RSVD = 2'h3
  } auto_type;

  typedef enum logic [1:0] {
    MOD_FOURTH = 2'h0,
    MOD_OFF    = 2'h1,
    MOD_SECOND = 2'h2,
    MOD_THIRD  = 2'h3
  } mod_type;

  localparam logic [2:0] ORDER_NONE   = 3'h0;
  localparam logic [2:0] ORDER_SECOND = 3'h2;
  localparam logic [2:0] ORDER_THIRD  = 3'h3;
  localparam logic [2:0] ORDER_FOURTH = 3'h4;

  typedef struct packed {
    logic     main_pump_highz;
    logic     main_pump_polarity;
    logic     aux_pump_highz;
    logic     aux_pump_polarity;
    logic     denominator_width_select;
    mod_type  modulator_order;
    auto_type auto_power_up;
    logic     reference_doubler_enable;
    logic     diff_reference_enable;
    sel_type  output_selector;
  } func_ctrl_type;

  localparam func_ctrl_type FUNC_CTRL_RESET = 15'h0000;

  typedef struct packed {
    logic dig_main;
    logic dig_aux;
    logic ana_main;
    logic ana_aux;
    logic aux_ref_div;
    logic aux_fb_div;
    logic main_ref_div;
    logic main_fb_div;
  } lock_src_type;
endpackage : pll_cfg_pkg

// ---- verilog/serial_word_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_word_capture
  import pll_cfg_pkg::*;
#(
  parameter int BITS = WORD_BITS
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ser_data_i,
  input  wire logic              ser_clk_i,
  input  wire logic              ser_load_i,
  output logic      [BITS-1:0]   word_o,
  output logic                   word_valid_o
);
  initial begin
    if (BITS != WORD_BITS) $error("serial word length unsupported");
  end

  localparam logic [4:0] CNT_FULL = 5'(BITS);

  // three stages: two for crossing, one for edge detect
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic [1:0] sclk_reg;
  logic [1:0] sclk_next;
  logic [1:0] load_reg;
  logic [1:0] load_next;
  logic       data_reg;
  logic       data_next;
  logic [BITS-1:0] shift_reg;
  logic [BITS-1:0] shift_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [BITS-1:0] word_next;
  logic       valid_next;
  logic       sclk_rise;
  logic       load_rise;

  always_comb begin
    sync_next  = {ser_load_i, ser_clk_i, ser_data_i};
    sclk_next  = {sclk_reg[0], sync_reg[1]};
    load_next  = {load_reg[0], sync_reg[2]};
    data_next  = sync_reg[0];
    sclk_rise  = sclk_reg[0] & ~sclk_reg[1];
    load_rise  = load_reg[0] & ~load_reg[1];
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    word_next  = word_o;
    valid_next = 1'b0;
    if (load_rise) begin
      // only a complete word is handed on
      valid_next = (cnt_reg == CNT_FULL); // [RQ17]
      if (cnt_reg == CNT_FULL) begin
        word_next = shift_reg;
      end
      cnt_next = 5'h00;
    end else if (sclk_rise) begin
      shift_next = {shift_reg[BITS-2:0], data_reg};
      if (cnt_reg != CNT_FULL) begin
        cnt_next = cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_reg     <= 3'h0;
      sclk_reg     <= 2'h0;
      load_reg     <= 2'h0;
      data_reg     <= 1'h0;
      shift_reg    <= '0;
      cnt_reg      <= 5'h00;
      word_o       <= '0;
      word_valid_o <= 1'h0;
    end else begin
      sync_reg     <= sync_next;
      sclk_reg     <= sclk_next;
      load_reg     <= load_next;
      data_reg     <= data_next;
      shift_reg    <= shift_next;
      cnt_reg      <= cnt_next;
      word_o       <= word_next;
      word_valid_o <= valid_next;
    end
  end
endmodule : serial_word_capture
`default_nettype wire

// ---- test/serial_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input  wire logic clk_i,
  output logic      ser_data_o,
  output logic      ser_clk_o,
  output logic      ser_load_o
);
  initial begin
    ser_data_o = 1'b0;
    ser_clk_o  = 1'b0;
    ser_load_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sends the low n bits of w, msb first, then pulses load
  task automatic send_bits(input logic [23:0] w, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      @(posedge clk_i);
      ser_data_o <= w[k];
      ser_clk_o  <= 1'b0;
      repeat (3) @(posedge clk_i);
      ser_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    ser_clk_o  <= 1'b0;
    ser_data_o <= ~ser_data_o;
    repeat (3) @(posedge clk_i);
    ser_load_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    ser_load_o <= 1'b0;
  endtask : send_bits
endmodule : serial_host_model
`default_nettype wire

// ---- test/pll_function_config_decode_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_function_config_decode_test
  import pll_cfg_pkg::*;
;
  typedef struct packed {
    logic [3:0]   sel;
    lock_src_type lock;
    logic         exp_o;
    logic         exp_oe;
    logic         chk_o;
  } row_type;

  logic         clk, nrst, ser_data, ser_clk, ser_load;
  lock_src_type lock_src;
  logic [11:0]  num_lower;
  logic         test_lock, test_lock_oe, ref_diff, doubler, main_pol, aux_pol;
  logic         main_hz, aux_hz, main_pwr, aux_pwr, mod_en, wide;
  logic [2:0]   mod_order;
  logic [21:0]  numerator;
  logic [9:0]   denom_up;
  logic [14:0]  f;
  logic         prev;
  int           err_count, tests_run, cycles, main_cnt, aux_cnt;
  logic [2:0]   order_tab [4] = '{ORDER_FOURTH, ORDER_NONE, ORDER_SECOND, ORDER_THIRD};
  row_type      rows [19] = '{
    '{4'h0, 8'hFF, 1'b0, 1'b0, 1'b0}, '{4'h1, 8'h00, 1'b1, 1'b1, 1'b1},
    '{4'h2, 8'hFF, 1'b0, 1'b1, 1'b1}, '{4'h3, 8'h80, 1'b0, 1'b1, 1'b1},
    '{4'h3, 8'hC0, 1'b1, 1'b1, 1'b1}, '{4'h4, 8'h80, 1'b1, 1'b1, 1'b1},
    '{4'h5, 8'h80, 1'b0, 1'b1, 1'b1}, '{4'h6, 8'h20, 1'b0, 1'b1, 1'b1},
    '{4'h6, 8'h30, 1'b0, 1'b0, 1'b1}, '{4'h7, 8'h20, 1'b0, 1'b0, 1'b1},
    '{4'h8, 8'h20, 1'b0, 1'b1, 1'b1}, '{4'h9, 8'h20, 1'b0, 1'b1, 1'b1},
    '{4'hA, 8'h20, 1'b1, 1'b1, 1'b1}, '{4'hB, 8'h20, 1'b0, 1'b1, 1'b1},
    '{4'hB, 8'h10, 1'b1, 1'b1, 1'b1}, '{4'hC, 8'h00, 1'b0, 1'b1, 1'b0},
    '{4'hD, 8'h00, 1'b0, 1'b1, 1'b0}, '{4'hE, 8'h00, 1'b0, 1'b1, 1'b0},
    '{4'hF, 8'h00, 1'b0, 1'b1, 1'b0}};

  serial_host_model serial_host_model_inst (
    .clk_i(clk), .ser_data_o(ser_data), .ser_clk_o(ser_clk), .ser_load_o(ser_load));

  pll_function_config_decode pll_function_config_decode_inst (
    .CLK_I(clk), .NRST_I(nrst), .SER_DATA_I(ser_data), .SER_CLK_I(ser_clk),
    .SER_LOAD_I(ser_load), .LOCK_SRC_I(lock_src), .NUMERATOR_LOWER_I(num_lower),
    .TEST_LOCK_O(test_lock), .TEST_LOCK_OE_O(test_lock_oe), .REF_DIFF_SEL_O(ref_diff),
    .REF_DOUBLER_EN_O(doubler), .MAIN_PUMP_POL_O(main_pol), .AUX_PUMP_POL_O(aux_pol),
    .MAIN_PUMP_HIGHZ_O(main_hz), .AUX_PUMP_HIGHZ_O(aux_hz), .MAIN_POWER_UP_O(main_pwr),
    .AUX_POWER_UP_O(aux_pwr), .MOD_ENABLE_O(mod_en), .MOD_ORDER_O(mod_order),
    .WIDE_MODE_O(wide), .NUMERATOR_O(numerator), .DENOM_UPPER_O(denom_up));

  ////////////////////////////////////////////////////////////////////////////
  // clock, timeout, pulse counters
  initial clk = 1'b0;
  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (main_pwr === 1'b1) main_cnt++;
    if (aux_pwr === 1'b1) aux_cnt++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic send(input logic [23:0] w);
    serial_host_model_inst.send_bits(w, 24);
    repeat (12) @(posedge clk);
  endtask : send

  task automatic send_ext(input logic [9:0] du, input logic [9:0] nu);
    send({du, nu, ADDR_FRAC_EXT});
  endtask : send_ext

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst = 1'b0;
    lock_src = '0;
    num_lower = 12'h000;
    repeat (8) @(posedge clk);
    check({test_lock_oe, test_lock, mod_en, mod_order, wide}, 32'h0);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    check(test_lock_oe, 1'b0);
    check({mod_en, mod_order}, {1'b1, ORDER_FOURTH});
    $display("test reset done");

    for (int i = 0; i < 19; i++) begin
      f = {i[0], i[1], i[2], i[3], i[0] ^ i[1], i[1:0], 2'h0, i[2], i[3], rows[i].sel};
      @(posedge clk);
      lock_src <= rows[i].lock;
      send({5'h00, f, ADDR_FUNC_CTRL});
      check(test_lock_oe, rows[i].exp_oe);
      if (rows[i].chk_o) check(test_lock, rows[i].exp_o);
      check(ref_diff, f[4]);
      check(doubler, f[5]);
      check(aux_pol, f[11]);
      check(main_pol, f[13]);
      check({main_hz, aux_hz}, {f[14], f[12]});
      check(wide, f[10]);
      check({mod_en, mod_order}, {f[9:8] != 2'h1, order_tab[f[9:8]]});
    end
    $display("test table done");

    for (int s = 12; s < 16; s++) begin
      lock_src <= 8'h00;
      send({5'h00, 11'h000, s[3:0], ADDR_FUNC_CTRL});
      for (int k = 0; k < 2; k++) begin
        prev = ~test_lock;
        lock_src <= 8'h01 << (15 - s);
        repeat (6) @(posedge clk);
        lock_src <= 8'h00;
        repeat (6) @(posedge clk);
        check(test_lock, prev);
      end
    end
    $display("test divider done");

    num_lower <= 12'hABC;
    send({5'h00, 15'h0400, ADDR_FUNC_CTRL});
    send_ext(10'h155, 10'h2A3);
    check(numerator, {10'h2A3, 12'hABC});
    check(denom_up, 10'h155);
    num_lower <= 12'hFFF;
    send_ext(10'h3FF, 10'h3FF);
    check(numerator, 22'h3FFFFF);
    send({5'h00, 15'h0000, ADDR_FUNC_CTRL});
    check(numerator, 22'h000FFF);
    send({5'h00, 15'h0400, ADDR_FUNC_CTRL});
    num_lower <= 12'h001;
    send_ext(10'h000, 10'h000);
    check(numerator, 22'h000001);
    $display("test numerator done");

    send({5'h00, 15'h0000, ADDR_FUNC_CTRL});
    serial_host_model_inst.send_bits({5'h00, 15'h0400, ADDR_FUNC_CTRL}, 23);
    repeat (12) @(posedge clk);
    check(wide, 1'b0);
    send({5'h00, 15'h0400, 4'h9});
    check(wide, 1'b0);
    $display("test refusal done");

    for (int a = 0; a < 4; a++) begin
      send({5'h00, 4'hF, 3'h0, a[1:0], 6'h00, ADDR_FUNC_CTRL});
      main_cnt = 0;
      aux_cnt = 0;
      send(24'h000010);
      check(main_cnt, (a == 1 || a == 2));
      check(aux_cnt, (a == 2));
      check(main_hz, !(a == 1 || a == 2));
      check(aux_hz, (a != 2));
    end
    $display("test auto power-up done");
    send({5'h00, 15'h0401, ADDR_FUNC_CTRL});
    check({wide, test_lock_oe, test_lock}, 3'h7);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check({wide, test_lock_oe, mod_en, mod_order}, 32'h0);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    check({wide, test_lock_oe, mod_en, mod_order}, {2'h0, 1'b1, ORDER_FOURTH});
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : pll_function_config_decode_test
`default_nettype wire
